//--- clk_ctrl_defs.svh
`ifndef CLK_CTRL_DEFS_SVH
`define CLK_CTRL_DEFS_SVH

// Register byte offsets.
`define CFG1_OFF 8'h00
`define OSC_CTRL_OFF 8'h04
`define CFG2_OFF 8'h08
`define IFG_OFF 8'h0C
`define STATUS_OFF 8'h10
`define INT_STAT_OFF 8'h14
`define INT_MASK_OFF 8'h18

// Field positions.
`define RANGE_MSB 3
`define HANG_EN_BIT 7
`define TAP_MSB 7
`define TAP_LSB 5
`define MOD_MSB 4
`define MAIN_SEL_MSB 7
`define MAIN_SEL_LSB 6
`define SUB_SEL_BIT 3
`define FAULT_BIT 0

// Reset values.
`define RANGE_RESET 4'h7
`define OSC_CTRL_RESET 8'h00
`define MAIN_SEL_RESET 2'h0
`define INT_MASK_RESET 4'h0

// Range thresholds.
`define RANGE_HI_LIMIT 4'hD
`define RANGE_LO_LIMIT 4'hC
`define RANGE_MAX 4'hF

// Timing.
`define DEAD_TIME_NS 20000
`define CLK_FREQ_MHZ 200

// Bus answers.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

//--- clk_ctrl_pkg.sv
package clk_ctrl_pkg;
  typedef logic [3:0] range_t;
  typedef logic [2:0] tap_t;
  typedef logic [4:0] mod_t;
  typedef enum logic [3:0] {
    EV_DEAD = 4'h1,
    EV_HANG = 4'h2,
    EV_START = 4'h4,
    EV_FAULT = 4'h8
  } event_e;
endpackage : clk_ctrl_pkg

//--- dco_range_and_clock_source_control.sv
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "clk_ctrl_defs.svh"
module dco_range_and_clock_source_control #(
  parameter int DEAD_TIME_NS = `DEAD_TIME_NS,
  parameter int CLK_FREQ_MHZ = `CLK_FREQ_MHZ
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Crystal or low-power oscillator fault detector
  input wire logic osc_fault_in,
  // Oscillator control
  output logic osc_enable,
  output logic osc_clock_valid,
  output clk_ctrl_pkg::range_t osc_range_value,
  output clk_ctrl_pkg::tap_t osc_tap_select,
  output clk_ctrl_pkg::mod_t osc_modulation_select,
  output logic sub_main_clock_stuck_high,
  // Interrupt
  output logic irq
);
  // Longest stall, rounded down to whole cycles.
  localparam int DEAD_CYCLES = DEAD_TIME_NS * CLK_FREQ_MHZ / 1000;
  localparam int LEN_W = $clog2(DEAD_CYCLES + 2);

  // Bus holding registers.
  logic aw_held_reg;
  logic [7:0] aw_addr_reg;
  logic w_held_reg;
  logic [7:0] w_data_reg;
  logic w_lane_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // Clock configuration state.
  clk_ctrl_pkg::range_t range_reg;
  clk_ctrl_pkg::range_t range_next;
  logic hang_en_reg;
  clk_ctrl_pkg::tap_t tap_reg;
  clk_ctrl_pkg::mod_t mod_reg;
  logic [1:0] main_sel_reg;
  logic sub_sel_reg;
  logic fault_reg;
  logic fault_next;
  logic osc_on_reg;
  logic osc_on_next;
  logic hung_reg;
  logic [3:0] int_stat_reg;
  logic [3:0] int_stat_next;
  logic [3:0] int_mask_reg;

  // Write path.
  wire wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  wire wr_cfg1 = wr_fire && (aw_addr_reg == `CFG1_OFF);
  wire wr_ctrl = wr_fire && (aw_addr_reg == `OSC_CTRL_OFF);
  wire wr_cfg2 = wr_fire && (aw_addr_reg == `CFG2_OFF);
  wire wr_ifg = wr_fire && (aw_addr_reg == `IFG_OFF);
  wire wr_istat = wr_fire && (aw_addr_reg == `INT_STAT_OFF);
  wire wr_imask = wr_fire && (aw_addr_reg == `INT_MASK_OFF);
  wire wr_ro = wr_fire && (aw_addr_reg == `STATUS_OFF);
  wire wr_hit = wr_cfg1 || wr_ctrl || wr_cfg2 || wr_ifg || wr_istat || wr_imask || wr_ro;
  wire range_wr = wr_cfg1 && w_lane_reg;
  wire ctrl_wr = wr_ctrl && w_lane_reg;
  wire [3:0] new_range = w_data_reg[`RANGE_MSB:0];
  wire [7:0] cur_ctrl = {tap_reg, mod_reg};

  // Hazard detection on the oscillator settings.
  wire cross_down = (range_reg > `RANGE_HI_LIMIT) && (new_range < `RANGE_LO_LIMIT);
  wire cross_up = (range_reg < `RANGE_LO_LIMIT) && (new_range > `RANGE_HI_LIMIT);
  wire range_hazard = range_wr && (cross_down || cross_up);
  wire ctrl_hazard = ctrl_wr && (range_reg == `RANGE_MAX) && (w_data_reg != cur_ctrl);
  wire hazard = range_hazard || ctrl_hazard;
  wire hang_now = hazard && hang_en_reg && !hung_reg;
  wire start_dead = hazard && !hang_en_reg && !hung_reg;
  wire dead_busy;

  // Source selection.
  wire main_dco = !main_sel_reg[1];
  wire sub_dco = !sub_sel_reg;

  // Read path.
  wire rd_fire = arvalid && arready;
  wire [3:0] status_word = {sub_main_clock_stuck_high, hung_reg, dead_busy, osc_on_reg};
  wire rd_cfg1 = (araddr == `CFG1_OFF);
  wire rd_ctrl = (araddr == `OSC_CTRL_OFF);
  wire rd_cfg2 = (araddr == `CFG2_OFF);
  wire rd_ifg = (araddr == `IFG_OFF);
  wire rd_stat = (araddr == `STATUS_OFF);
  wire rd_istat = (araddr == `INT_STAT_OFF);
  wire rd_imask = (araddr == `INT_MASK_OFF);
  wire rd_hit = rd_cfg1 || rd_ctrl || rd_cfg2 || rd_ifg || rd_stat || rd_istat || rd_imask;
  wire [7:0] rd_byte =
    rd_cfg1 ? {hang_en_reg, 3'h0, range_reg} :
    rd_ctrl ? cur_ctrl :
    rd_cfg2 ? {main_sel_reg, 2'h0, sub_sel_reg, 3'h0} :
    rd_ifg ? {7'h00, fault_reg} :
    rd_stat ? {4'h0, status_word} :
    rd_istat ? {4'h0, int_stat_reg} :
    rd_imask ? {4'h0, int_mask_reg} : 8'h00;

  // New settings become visible only at the edge that completes the write.
  assign range_next = range_wr ? new_range : range_reg;
  // Hardware set wins over a software clear in the same cycle.
  assign fault_next = osc_fault_in || (wr_ifg && w_lane_reg ? w_data_reg[`FAULT_BIT] : fault_reg);
  // Once off, only the main select or the fault logic can restart the oscillator.
  assign osc_on_next = (main_dco || fault_reg) ? 1'b1 :
                       !sub_dco ? 1'b0 : osc_on_reg;

  wire [3:0] ev =
    (start_dead ? clk_ctrl_pkg::EV_DEAD : 4'h0) |
    (hang_now ? clk_ctrl_pkg::EV_HANG : 4'h0) |
    (osc_on_next && !osc_on_reg ? clk_ctrl_pkg::EV_START : 4'h0) |
    (osc_fault_in && !fault_reg ? clk_ctrl_pkg::EV_FAULT : 4'h0);
  wire [3:0] w1c = (wr_istat && w_lane_reg) ? w_data_reg[3:0] : 4'h0;
  assign int_stat_next = ev | (int_stat_reg & ~w1c);

  // Outputs.
  assign awready = !aw_held_reg;
  assign wready = !w_held_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = !rvalid_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign osc_enable = osc_on_reg;
  // The output is blanked through any stall so no runt cycle escapes.
  assign osc_clock_valid = osc_on_reg && !dead_busy && !hung_reg;
  assign osc_range_value = range_reg;
  assign osc_tap_select = tap_reg;
  assign osc_modulation_select = mod_reg;
  assign sub_main_clock_stuck_high = sub_dco && !osc_on_reg;
  assign irq = |(int_stat_reg & int_mask_reg);

  osc_dead_timer #(
    .CYCLES(DEAD_CYCLES)
  ) u_dead_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(start_dead),
    .busy(dead_busy)
  );

  // Write channel capture and response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_held_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_lane_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= wdata[7:0];
        w_lane_reg <= wstrb[0];
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read channel.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h000000, rd_byte};
      rresp_reg <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Oscillator settings.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      range_reg <= `RANGE_RESET;
      hang_en_reg <= 1'b0;
      {tap_reg, mod_reg} <= `OSC_CTRL_RESET;
      main_sel_reg <= `MAIN_SEL_RESET;
      sub_sel_reg <= 1'b0;
    end else begin
      range_reg <= range_next;
      if (range_wr) begin
        hang_en_reg <= w_data_reg[`HANG_EN_BIT];
      end
      if (ctrl_wr) begin
        {tap_reg, mod_reg} <= w_data_reg;
      end
      if (wr_cfg2 && w_lane_reg) begin
        main_sel_reg <= w_data_reg[`MAIN_SEL_MSB:`MAIN_SEL_LSB];
        sub_sel_reg <= w_data_reg[`SUB_SEL_BIT];
      end
    end
  end

  // Oscillator run state, fault flag and interrupts.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_reg <= 1'b0;
      osc_on_reg <= 1'b0;
      hung_reg <= 1'b0;
      int_stat_reg <= 4'h0;
      int_mask_reg <= `INT_MASK_RESET;
    end else begin
      fault_reg <= fault_next;
      osc_on_reg <= osc_on_next;
      // Only power-up clear releases a hung oscillator.
      if (hang_now) begin
        hung_reg <= 1'b1;
      end
      int_stat_reg <= int_stat_next;
      if (wr_imask && w_lane_reg) begin
        int_mask_reg <= w_data_reg[3:0];
      end
    end
  end

  // Helper: length of the current stall, restarted on each trigger.
  logic [LEN_W-1:0] dead_len_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dead_len_reg <= '0;
    end else if (start_dead) begin
      dead_len_reg <= '0;
    end else if (dead_busy) begin
      dead_len_reg <= dead_len_reg + LEN_W'(1);
    end
  end

  property p_cross_stall;
    @(posedge aclk) disable iff (!aresetn)
      (range_hazard && !hang_en_reg && !hung_reg) |=> (dead_busy && !osc_clock_valid);
  endproperty
  a_cross_stall: assert property (p_cross_stall)
    else $error("Range crossing did not stall the oscillator output.");

  property p_stall_length;
    @(posedge aclk) disable iff (!aresetn)
      $fell(dead_busy) |-> (dead_len_reg == LEN_W'(DEAD_CYCLES));
  endproperty
  a_stall_length: assert property (p_stall_length)
    else $error("Oscillator stall did not last the dead time.");

  property p_hang_holds;
    @(posedge aclk) disable iff (!aresetn)
      hang_now |=> (hung_reg && !osc_clock_valid) [*8];
  endproperty
  a_hang_holds: assert property (p_hang_holds)
    else $error("Hung oscillator recovered without power-up clear.");

  property p_ctrl_stall;
    @(posedge aclk) disable iff (!aresetn)
      ctrl_hazard |=> !osc_clock_valid;
  endproperty
  a_ctrl_stall: assert property (p_ctrl_stall)
    else $error("Tap or modulation change at top range did not stall.");

  property p_reset_range;
    @(posedge aclk) disable iff (!aresetn)
      !$past(aresetn) |-> (range_reg == `RANGE_RESET) && (osc_range_value == `RANGE_RESET);
  endproperty
  a_reset_range: assert property (p_reset_range)
    else $error("Range select not at default after power-up clear.");

  property p_off_when_unused;
    @(posedge aclk) disable iff (!aresetn)
      (!main_dco && !sub_dco && !fault_reg) |=> !osc_enable;
  endproperty
  a_off_when_unused: assert property (p_off_when_unused)
    else $error("Oscillator left running with no clock selecting it.");

  property p_sub_no_restart;
    @(posedge aclk) disable iff (!aresetn)
      (!osc_on_reg && !main_dco && !fault_reg && sub_dco) |=>
        (!osc_enable && sub_main_clock_stuck_high);
  endproperty
  a_sub_no_restart: assert property (p_sub_no_restart)
    else $error("Sub-main select alone restarted the oscillator.");

  property p_main_start;
    @(posedge aclk) disable iff (!aresetn)
      (wr_cfg2 && w_lane_reg && !w_data_reg[`MAIN_SEL_MSB]) |=> ##1 osc_enable;
  endproperty
  a_main_start: assert property (p_main_start)
    else $error("Main source select of the oscillator did not start it.");

  property p_fault_start;
    @(posedge aclk) disable iff (!aresetn)
      osc_fault_in |=> fault_reg ##1 osc_enable;
  endproperty
  a_fault_start: assert property (p_fault_start)
    else $error("Fault flag did not start the oscillator.");

  property p_apply_on_write;
    @(posedge aclk) disable iff (!aresetn)
      ($changed(osc_range_value) || $changed(osc_tap_select)) |-> $past(wr_fire);
  endproperty
  a_apply_on_write: assert property (p_apply_on_write)
    else $error("Oscillator setting changed without a completed write.");
endmodule : dco_range_and_clock_source_control

//--- dco_range_and_clock_source_control_tb_top.sv
`timescale 1ns/1ps
module dco_range_and_clock_source_control_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic osc_fault_in = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, osc_enable, osc_clock_valid;
  logic sub_main_clock_stuck_high, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  clk_ctrl_pkg::range_t osc_range_value;
  clk_ctrl_pkg::tap_t osc_tap_select;
  clk_ctrl_pkg::mod_t osc_modulation_select;
  int err_total = 0;
  int samples_checked = 0;
  int seed = 5215;
  int rng_m;
  logic [31:0] d;
  logic [1:0] r;
  int steps[10] = '{13, 3, 7, 14, 13, 7, 12, 13, 7, 15};

  always #2.5 aclk = ~aclk;

  // Dead time shortened to 20 cycles so the hazard cases stay quick.
  dco_range_and_clock_source_control #(
    .DEAD_TIME_NS(100),
    .CLK_FREQ_MHZ(200)
  ) i_dco_range_and_clock_source_control (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .osc_fault_in(osc_fault_in), .osc_enable(osc_enable), .osc_clock_valid(osc_clock_valid),
    .osc_range_value(osc_range_value), .osc_tap_select(osc_tap_select),
    .osc_modulation_select(osc_modulation_select),
    .sub_main_clock_stuck_high(sub_main_clock_stuck_high), .irq(irq)
  );

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic tmo();
    chk(32'h0000_0000, 32'h0000_0001);
    wrap_up();
  endtask : tmo

  // Ready is sampled at the falling edge, where it already equals its value at the next rise.
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    logic at, wt, ah, wh, bt;
    ah = 1'b0;
    wh = 1'b0;
    bt = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int n = 0; n < 50 && !(ah && wh); n++) begin
      @(negedge aclk);
      at = awvalid && awready;
      wt = wvalid && wready;
      @(posedge aclk);
      if (at) begin
        awvalid <= 1'b0;
        ah = 1'b1;
      end
      if (wt) begin
        wvalid <= 1'b0;
        wh = 1'b1;
      end
    end
    if (!(ah && wh)) tmo();
    bready <= 1'b1;
    for (int n = 0; n < 50 && !bt; n++) begin
      @(negedge aclk);
      bt = bvalid;
      r = bresp;
      @(posedge aclk);
    end
    bready <= 1'b0;
    if (!bt) tmo();
  endtask : axw

  task automatic axr(input logic [7:0] a);
    logic t;
    t = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    for (int n = 0; n < 50 && !t; n++) begin
      @(negedge aclk);
      t = arready;
      @(posedge aclk);
    end
    arvalid <= 1'b0;
    rready <= 1'b1;
    if (!t) tmo();
    t = 1'b0;
    for (int n = 0; n < 50 && !t; n++) begin
      @(negedge aclk);
      t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
    end
    rready <= 1'b0;
    if (!t) tmo();
  endtask : axr

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : do_reset

  // Model of the range hazard: crossing the band between 12 and 13 in either direction.
  function automatic bit hazard(input int o, input int n);
    return (o > 13 && n < 12) || (o < 12 && n > 13);
  endfunction : hazard

  initial begin
    do_reset();
    axr(8'h00); chk(d, 32'h0000_0007);
    axr(8'h04); chk(d, 32'h0000_0000);
    axr(8'h1C);
    chk(d, 32'h0000_0000);
    chk(r, 32'h0000_0002);
    axw(8'h1C, 32'h0000_00FF);
    chk(r, 32'h0000_0002);
    chk(osc_enable, 1'b1);
    axw(8'h14, 32'h0000_000F);
    chk(r, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      d = $random(seed) & 32'h0000_00FF;
      axw(8'h04, d);
      chk({osc_tap_select, osc_modulation_select}, d[7:0]);
      chk(osc_clock_valid, 1'b1);
    end
    rng_m = 7;
    axw(8'h00, 32'h0000_000F);
    @(negedge aclk);
    chk(osc_clock_valid, 1'b0);
    chk(osc_range_value, 4'hF);
    repeat (25) @(posedge aclk);
    chk(osc_clock_valid, 1'b1);
    axr(8'h14); chk(d[0], 1'b1);
    axw(8'h18, 32'h0000_0001);
    chk(irq, 1'b1);
    axw(8'h14, 32'h0000_0001);
    chk(irq, 1'b0);
    axw(8'h04, {24'h0, osc_tap_select ^ 3'h1, osc_modulation_select});
    @(negedge aclk);
    chk(osc_clock_valid, 1'b0);
    repeat (25) @(posedge aclk);
    rng_m = 15;
    foreach (steps[i]) begin
      axw(8'h00, steps[i]);
      @(negedge aclk);
      chk(osc_clock_valid, !hazard(rng_m, steps[i]));
      chk(osc_range_value, steps[i]);
      rng_m = steps[i];
      repeat (25) @(posedge aclk);
    end
    axw(8'h00, 32'h0000_000D);
    axw(8'h00, 32'h0000_0007);
    axw(8'h04, 32'h0000_00A5);
    chk(osc_clock_valid, 1'b1);
    chk({osc_tap_select, osc_modulation_select}, 32'h0000_00A5);
    axw(8'h00, 32'h0000_000D);
    // The hang enable only governs hazards of later writes, so it is armed first.
    axw(8'h00, 32'h0000_008F);
    axw(8'h00, 32'h0000_0083);
    repeat (30) @(posedge aclk);
    chk(osc_clock_valid, 1'b0);
    axr(8'h10); chk(d[2], 1'b1);
    do_reset();
    // The oscillator restarts at the edge that ends do_reset, so look one edge later.
    @(posedge aclk);
    chk(osc_clock_valid, 1'b1);
    axw(8'h08, 32'h0000_0088);
    repeat (3) @(posedge aclk);
    chk(osc_enable, 1'b0);
    axw(8'h08, 32'h0000_0080);
    repeat (3) @(posedge aclk);
    chk({osc_enable, sub_main_clock_stuck_high}, 2'b01);
    axw(8'h0C, 32'h0000_0001);
    repeat (3) @(posedge aclk);
    chk(osc_enable, 1'b1);
    axw(8'h0C, 32'h0000_0000);
    axw(8'h08, 32'h0000_0088);
    repeat (3) @(posedge aclk);
    chk(osc_enable, 1'b0);
    osc_fault_in <= 1'b1;
    @(posedge aclk);
    osc_fault_in <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(osc_enable, 1'b1);
    axr(8'h0C); chk(d, 32'h0000_0001);
    axw(8'h0C, 32'h0000_0000);
    axw(8'h08, 32'h0000_0040);
    repeat (3) @(posedge aclk);
    chk(osc_enable, 1'b1);
    wrap_up();
  end
endmodule : dco_range_and_clock_source_control_tb_top

//--- osc_dead_timer.sv
`timescale 1ns/1ps
module osc_dead_timer #(
  parameter int CYCLES = 4000
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic start,
  output logic busy
);
  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;

  // A restart while busy reloads the full interval.
  assign cnt_next = start ? LOAD :
                    (cnt_reg != '0) ? cnt_reg - CNT_W'(1) : cnt_reg;
  assign busy = (cnt_reg != '0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule : osc_dead_timer
